// ===== sim/pmic_peer.sv
module pmic_peer (
  input wire logic irq_oe,
  input wire logic irq_out,
  input wire logic hold_low,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Weak pull-up wins when nobody drives, so the input never floats
  assign pin_level = irq_oe ? irq_out : !hold_low;
endmodule

// ===== sim/pmic_sva.sv
module pmic_sva (
  input wire logic CLK,
  input wire logic RESETN,
  input wire pmic_pkg::pmic_req_t REQ,
  input wire logic RVALID,
  input wire pmic_pkg::pmic_line_t LINE,
  input wire logic MAC_TX_EN,
  input wire logic LINE_RX_DV,
  input wire logic MAC_CRS,
  input wire logic MAC_COL,
  input wire logic FULL_DUPLEX,
  input wire logic POWER_DOWN,
  input wire logic PD_IRQ_IN,
  input wire logic PD_IRQ_OE,
  input wire logic PD_IRQ_OUT,
  input wire logic DIAG_PAGE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // A clearing read of 0x12 with a quiet line must release the pin; new events win over clear
  sequence clear_read_s;
    REQ.rd && REQ.addr == 5'h12 && PD_IRQ_OE && !POWER_DOWN && $stable(LINE);
  endsequence
  sequence quiet_line_s;
    $stable(LINE) [*2];
  endsequence
  chk_read_answer: assert property (REQ.rd |=> RVALID)
    else $error("read got no answer");
  chk_no_spurious: assert property (!REQ.rd |=> !RVALID)
    else $error("answer without read");
  chk_full_no_col: assert property (FULL_DUPLEX |-> !MAC_COL)
    else $error("collision in full duplex");
  chk_full_crs_rx: assert property (FULL_DUPLEX && !$past(POWER_DOWN) |->
    MAC_CRS == $past(LINE_RX_DV)) else $error("carrier not receive only");
  chk_half_crs_both: assert property (!FULL_DUPLEX && !$past(POWER_DOWN) |->
    MAC_CRS == $past(MAC_TX_EN || LINE_RX_DV)) else $error("carrier wrong in half");
  chk_pin_released: assert property (clear_read_s ##1 quiet_line_s |=> PD_IRQ_OUT)
    else $error("pin not released after clear");
  chk_pin_powerdown: assert property ((!PD_IRQ_OE && !PD_IRQ_IN) [*2] |-> POWER_DOWN)
    else $error("pin low did not power down");
  chk_diag_page: assert property (REQ.wr && REQ.addr == 5'h13 |=> ##1
    DIAG_PAGE == ($past(REQ.wdata, 2) == 16'h0002)) else $error("page select wrong");
endmodule

// ===== sim/tb_phy_mode_interrupt_control.sv
module tb_phy_mode_interrupt_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RESETN = 0, STRAP_FIBER = 0, MAC_TX_EN = 0, LINE_RX_DV = 0, LINE_COL = 0;
  logic hold_low = 0, pin, RVALID, PD_IRQ_OUT, PD_IRQ_OE, MAC_CRS, MAC_COL, MAC_RX_DV;
  logic MEDIA_TX_EN, POWER_DOWN, FULL_DUPLEX, ED_TX_PULSE, DIAG_PAGE;
  logic [2:0] STRAP_LED = 3'h2, LED_FUNC = 3'h0, LED_OUT;
  logic [3:0] MAC_TXD = 4'h0, LINE_RXD = 4'h0, MAC_RXD, MEDIA_TXD;
  logic [15:0] RDATA, rv;
  pmic_pkg::pmic_req_t REQ = '0;
  pmic_pkg::pmic_line_t LINE = '0;
  int errors = 0, checked = 0, n;
  pmic_top dut (
    .CLK(CLK), .RESETN(RESETN), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID), .LINE(LINE),
    .STRAP_LED(STRAP_LED), .STRAP_FIBER(STRAP_FIBER), .LED_FUNC(LED_FUNC),
    .MAC_TX_EN(MAC_TX_EN), .MAC_TXD(MAC_TXD), .LINE_RX_DV(LINE_RX_DV), .LINE_RXD(LINE_RXD),
    .LINE_COL(LINE_COL), .PD_IRQ_IN(pin), .PD_IRQ_OUT(PD_IRQ_OUT), .PD_IRQ_OE(PD_IRQ_OE),
    .LED_OUT(LED_OUT), .MAC_CRS(MAC_CRS), .MAC_COL(MAC_COL), .MAC_RX_DV(MAC_RX_DV),
    .MAC_RXD(MAC_RXD), .MEDIA_TX_EN(MEDIA_TX_EN), .MEDIA_TXD(MEDIA_TXD),
    .POWER_DOWN(POWER_DOWN), .FULL_DUPLEX(FULL_DUPLEX), .ED_TX_PULSE(ED_TX_PULSE),
    .DIAG_PAGE(DIAG_PAGE)
  );
  pmic_peer peer (.irq_oe(PD_IRQ_OE), .irq_out(PD_IRQ_OUT), .hold_low(hold_low), .pin_level(pin));
  always #5 CLK = ~CLK;
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLK) REQ <= '{a, d, 1'b1, 1'b0};
    @(posedge CLK) REQ.wr <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge CLK) REQ <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge CLK) REQ.rd <= 1'b0;
    #1 rv = RDATA;
  endtask
  // Generous span: the energy-detect sleep period dominates the run
  initial begin
    repeat (40000) @(posedge CLK);
    errors++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    cyc(3);
    chk(16'(LED_OUT), 16'h0002);
    rd(5'h12);
    chk(rv, 16'h0000);
    @(posedge CLK) LED_FUNC <= 3'h7;
    cyc(3);
    chk(16'(LED_OUT), 16'h0005);
    wr(5'h18, 16'h0039);
    chk(16'(LED_OUT), 16'h0003);
    rd(5'h18);
    chk(rv, 16'h0039);
    $display("led test done");
    @(posedge CLK) begin MAC_TX_EN <= 1'b1; LINE_COL <= 1'b1; end
    cyc(2);
    chk(16'({MAC_CRS, MAC_COL}), 16'h0003);
    wr(5'h00, 16'h0100);
    chk(16'({FULL_DUPLEX, MAC_CRS, MAC_COL}), 16'h0004);
    @(posedge CLK) begin LINE_RX_DV <= 1'b1; LINE_RXD <= 4'h5; end
    cyc(2);
    chk(16'({MAC_CRS, MAC_RX_DV, MAC_RXD}), 16'h0035);
    @(posedge CLK) begin LINE_RX_DV <= 1'b0; LINE_COL <= 1'b0; MAC_TXD <= 4'ha; end
    wr(5'h00, 16'h4000);
    chk(16'({MAC_RX_DV, MAC_RXD, MEDIA_TX_EN}), 16'h0034);
    chk(16'(MEDIA_TXD), 16'h0000);
    rd(5'h10);
    chk(rv & 16'h0008, 16'h0008);
    @(posedge CLK) MAC_TX_EN <= 1'b0;
    wr(5'h00, 16'h0000);
    $display("duplex test done");
    @(posedge CLK) hold_low <= 1'b1;
    cyc(3);
    chk(16'(POWER_DOWN), 16'h0001);
    rd(5'h11);
    chk(rv, 16'h0000);
    wr(5'h11, 16'h0003);
    chk(16'({POWER_DOWN, PD_IRQ_OE, PD_IRQ_OUT}), 16'h0003);
    @(posedge CLK) hold_low <= 1'b0;
    wr(5'h12, 16'h0060);
    @(posedge CLK) LINE.link_up <= 1'b1;
    cyc(4);
    chk(16'(PD_IRQ_OUT), 16'h0000);
    rd(5'h12);
    chk(rv, 16'h2060);
    cyc(2);
    chk(16'(PD_IRQ_OUT), 16'h0001);
    $display("interrupt test done");
    wr(5'h13, 16'h0002);
    chk(16'(DIAG_PAGE), 16'h0001);
    wr(5'h13, 16'h0001);
    chk(16'(DIAG_PAGE), 16'h0000);
    @(posedge CLK) begin LINE.neg_pulse <= 1'b1; LINE.crossed_pairs <= 1'b1; end
    rd(5'h10);
    chk(rv & 16'h5000, 16'h5000);
    rd(5'h1a);
    chk(rv & 16'h0010, 16'h0010);
    @(posedge CLK) LINE.speed100 <= 1'b1;
    rd(5'h10);
    chk(rv & 16'h1000, 16'h0000);
    @(posedge CLK) LINE.negotiated <= 1'b1;
    rd(5'h10);
    chk(rv & 16'h1000, 16'h1000);
    @(posedge CLK) LINE.full_partner <= 1'b1;
    cyc(3);
    chk(16'(FULL_DUPLEX), 16'h0001);
    @(posedge CLK) LINE.parallel_det <= 1'b1;
    cyc(3);
    chk(16'(FULL_DUPLEX), 16'h0000);
    $display("status test done");
    wr(5'h1d, 16'h8000);
    chk(16'(POWER_DOWN), 16'h0001);
    for (n = 0; n < 20000 && ED_TX_PULSE !== 1'b1; n++) cyc(1);
    chk(16'(ED_TX_PULSE), 16'h0001);
    @(posedge CLK) LINE.energy <= 1'b1;
    cyc(5);
    chk(16'(POWER_DOWN), 16'h0000);
    $display("energy test done");
    @(posedge CLK) begin RESETN <= 1'b0; STRAP_FIBER <= 1'b1; STRAP_LED <= 3'h1; LINE <= '0; end
    cyc(3);
    @(posedge CLK) RESETN <= 1'b1;
    cyc(3);
    chk(16'(FULL_DUPLEX), 16'h0001);
    rd(5'h00);
    chk(rv & 16'h0100, 16'h0100);
    $display("fiber test done");
    end_of_test;
  end
endmodule
bind pmic_top pmic_sva chk (.CLK(CLK), .RESETN(RESETN), .REQ(REQ), .RVALID(RVALID), .LINE(LINE),
  .MAC_TX_EN(MAC_TX_EN), .LINE_RX_DV(LINE_RX_DV), .MAC_CRS(MAC_CRS), .MAC_COL(MAC_COL),
  .FULL_DUPLEX(FULL_DUPLEX), .POWER_DOWN(POWER_DOWN), .PD_IRQ_IN(PD_IRQ_IN),
  .PD_IRQ_OE(PD_IRQ_OE), .PD_IRQ_OUT(PD_IRQ_OUT), .DIAG_PAGE(DIAG_PAGE));

// ===== src/pmic_cfg.svh
`ifndef PMIC_CFG_SVH
`define PMIC_CFG_SVH
`define PMIC_ADDR_BMC 5'h00
`define PMIC_ADDR_STS 5'h10
`define PMIC_ADDR_ICTL 5'h11
`define PMIC_ADDR_ISM 5'h12
`define PMIC_ADDR_PAGE 5'h13
`define PMIC_ADDR_LED 5'h18
`define PMIC_ADDR_TBS 5'h1a
`define PMIC_ADDR_EDC 5'h1d
`define PMIC_BMC_DUPLEX 8
`define PMIC_BMC_PWRDN 11
`define PMIC_BMC_LOOP 14
`define PMIC_STS_LOOP 3
`define PMIC_STS_POL 12
`define PMIC_STS_XOVER 14
`define PMIC_TBS_POL 4
`define PMIC_ICTL_OE 0
`define PMIC_ICTL_EN 1
`define PMIC_EDC_EN 15
`define PMIC_DIAG_PAGE 16'h0002
`define PMIC_BMC_RST 16'h0000
`define PMIC_ZERO16 16'h0000
`define PMIC_ED_PULSE_NS 1000
`define PMIC_CLK_NS 10
`define PMIC_ED_PULSE_CYC (`PMIC_ED_PULSE_NS / `PMIC_CLK_NS)
`define PMIC_ED_PERIOD 32'h0000_4000
`endif

// ===== src/pmic_pkg.sv
package pmic_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pmic_req_t;
  typedef struct packed {
    logic link_up;
    logic speed100;
    logic negotiated;
    logic parallel_det;
    logic full_partner;
    logic energy;
    logic neg_pulse;
    logic crossed_pairs;
  } pmic_line_t;
  typedef enum logic [1:0] {
    PMIC_ED_ACTIVE = 2'b00,
    PMIC_ED_SLEEP = 2'b01,
    PMIC_ED_PULSE = 2'b10
  } pmic_ed_t;
endpackage

// ===== src/pmic_top.sv
// Contract
// - Each LED output's active level is set by its strap sampled at reset release.
// - LED direct control register forces LEDs; reads return register, not pins.
// - Half duplex: carrier sense follows transmit and receive activity.
// - Full duplex: no collision reporting; carrier sense follows receive only, or transmit when loopback is on.
// - Other MAC signals identical in both duplex modes.
// - Parallel-detected link settles in half duplex.
// - Control bit 8 selects duplex; in fiber it alone decides.
// - Fiber strap: strap zero loads duplex bit; other straps ignored.
// - Loopback bit 14 returns transmit data, blocks media, shows status bit 3.
// - Shared pin is power-down input until output-enable bit set.
// - Pin low as input means power-down, like control bit 11.
// - Registers work in power-down; output-enable disconnects power-down input.
// - Interrupts off at reset; global enable and per-source masks gate pin.
// - Enabled pending interrupt drives pin low through a register, one cycle after the flags.
// - Upper status byte shows pending; a read of 0x12 clears it, bar same-cycle events, and releases pin.
// - Energy detect: sleep idle, pulse periodically, wake on line activity.
// - Page select value 2 exposes diagnostics page.
// - Polarity reversal flagged from negative pulses in two status bits.
// - Polarity valid only at 10 Mb/s or negotiated 100 Mb/s.
// - Crossed-pair selection reported in status bit 14.
`include "pmic_cfg.svh"
module pmic_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire pmic_pkg::pmic_req_t REQ,
  output logic [15:0] RDATA,
  output logic RVALID,
  input wire pmic_pkg::pmic_line_t LINE,
  input wire logic [2:0] STRAP_LED,
  input wire logic STRAP_FIBER,
  input wire logic [2:0] LED_FUNC,
  input wire logic MAC_TX_EN,
  input wire logic [3:0] MAC_TXD,
  input wire logic LINE_RX_DV,
  input wire logic [3:0] LINE_RXD,
  input wire logic LINE_COL,
  input wire logic PD_IRQ_IN,
  output logic PD_IRQ_OUT,
  output logic PD_IRQ_OE,
  output logic [2:0] LED_OUT,
  output logic MAC_CRS,
  output logic MAC_COL,
  output logic MAC_RX_DV,
  output logic [3:0] MAC_RXD,
  output logic MEDIA_TX_EN,
  output logic [3:0] MEDIA_TXD,
  output logic POWER_DOWN,
  output logic FULL_DUPLEX,
  output logic ED_TX_PULSE,
  output logic DIAG_PAGE
);
  logic [15:0] bmc_ff;
  logic [1:0] ictl_ff;
  logic [7:0] mask_ff;
  logic [7:0] pend_ff;
  logic [15:0] page_ff;
  logic [15:0] led_ff;
  logic [15:0] edc_ff;
  logic [2:0] led_pol_ff;
  logic strap_done_ff;
  logic fiber_ff;
  logic link_ff;
  logic energy_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic pd_irq_out_ff;
  logic pd_irq_oe_ff;
  logic [2:0] led_out_ff;
  logic crs_ff;
  logic col_ff;
  logic rx_dv_ff;
  logic [3:0] rxd_ff;
  logic mtx_en_ff;
  logic [3:0] mtxd_ff;
  logic pwr_ff;
  logic ed_pulse_ff;
  pmic_pkg::pmic_ed_t ed_ff;
  logic [31:0] ed_cnt_ff;
  logic full_dup;
  logic loop_en;
  logic pol_valid;
  logic [7:0] events;
  logic [15:0] rd_mux;
  logic ed_en;
  logic pin_pd;
  logic dup_ff;
  logic pd_out_ff;
  logic diag_ff;

  // Strap capture at first clock after release, not in the async reset branch
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_done_ff <= 1'b0;
      led_pol_ff <= 3'b000;
      fiber_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      led_pol_ff <= STRAP_LED;
      fiber_ff <= STRAP_FIBER;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bmc_ff <= `PMIC_BMC_RST;
    end else if (!strap_done_ff) begin
      if (STRAP_FIBER) begin
        bmc_ff[`PMIC_BMC_DUPLEX] <= STRAP_LED[0];
      end
    end else if (REQ.wr && REQ.addr == `PMIC_ADDR_BMC) begin
      bmc_ff <= REQ.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ictl_ff <= 2'b00;
      mask_ff <= 8'h00;
      page_ff <= `PMIC_ZERO16;
      led_ff <= `PMIC_ZERO16;
      edc_ff <= `PMIC_ZERO16;
    end else if (REQ.wr) begin
      case (REQ.addr)
        `PMIC_ADDR_ICTL: ictl_ff <= REQ.wdata[1:0];
        `PMIC_ADDR_ISM: mask_ff <= REQ.wdata[7:0];
        `PMIC_ADDR_PAGE: page_ff <= REQ.wdata;
        `PMIC_ADDR_LED: led_ff <= REQ.wdata;
        `PMIC_ADDR_EDC: edc_ff <= REQ.wdata;
        default: ;
      endcase
    end
  end

  // Fiber has no negotiation; partner ability only counts when negotiated
  always_comb begin
    if (fiber_ff || !LINE.link_up) begin
      full_dup = bmc_ff[`PMIC_BMC_DUPLEX];
    end else if (LINE.parallel_det) begin
      full_dup = 1'b0;
    end else if (LINE.negotiated) begin
      full_dup = LINE.full_partner;
    end else begin
      full_dup = bmc_ff[`PMIC_BMC_DUPLEX];
    end
  end

  assign loop_en = bmc_ff[`PMIC_BMC_LOOP];
  assign pol_valid = !LINE.speed100 || (LINE.negotiated && !LINE.parallel_det);
  assign ed_en = edc_ff[`PMIC_EDC_EN];
  assign pin_pd = bmc_ff[`PMIC_BMC_PWRDN] || (!ictl_ff[`PMIC_ICTL_OE] && !PD_IRQ_IN);

  // Bit 5 link change, bit 6 energy change; other sources not in this block
  always_comb begin
    events = 8'h00;
    events[5] = LINE.link_up != link_ff;
    events[6] = LINE.energy != energy_ff;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      link_ff <= 1'b0;
      energy_ff <= 1'b0;
    end else begin
      link_ff <= LINE.link_up;
      energy_ff <= LINE.energy;
    end
  end

  // New event in the clearing read cycle survives the clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_ff <= 8'h00;
    end else if (REQ.rd && REQ.addr == `PMIC_ADDR_ISM) begin
      pend_ff <= events & mask_ff;
    end else begin
      pend_ff <= pend_ff | (events & mask_ff);
    end
  end

  always_comb begin
    rd_mux = `PMIC_ZERO16;
    case (REQ.addr)
      `PMIC_ADDR_BMC: rd_mux = bmc_ff;
      `PMIC_ADDR_STS: begin
        rd_mux[0] = LINE.link_up;
        rd_mux[1] = !LINE.speed100;
        rd_mux[2] = full_dup;
        rd_mux[`PMIC_STS_LOOP] = loop_en;
        rd_mux[`PMIC_STS_POL] = LINE.neg_pulse && pol_valid;
        rd_mux[`PMIC_STS_XOVER] = LINE.crossed_pairs;
      end
      `PMIC_ADDR_ICTL: rd_mux = {14'h0000, ictl_ff};
      `PMIC_ADDR_ISM: rd_mux = {pend_ff, mask_ff};
      `PMIC_ADDR_PAGE: rd_mux = page_ff;
      `PMIC_ADDR_LED: rd_mux = led_ff;
      `PMIC_ADDR_TBS: rd_mux[`PMIC_TBS_POL] = LINE.neg_pulse && pol_valid;
      `PMIC_ADDR_EDC: rd_mux = edc_ff;
      default: rd_mux = `PMIC_ZERO16;
    endcase
  end

  // Reads served even in power-down
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= `PMIC_ZERO16;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REQ.rd;
      rdata_ff <= REQ.rd ? rd_mux : rdata_ff;
    end
  end

  // Pin in output mode ignores the input, so power-down from pin releases
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_ff <= 1'b0;
    end else begin
      pwr_ff <= pin_pd;
    end
  end

  // Status pins registered so every output leaves a flip-flop
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dup_ff <= 1'b0;
      pd_out_ff <= 1'b0;
      diag_ff <= 1'b0;
    end else begin
      dup_ff <= full_dup;
      pd_out_ff <= pin_pd || (ed_ff != pmic_pkg::PMIC_ED_ACTIVE);
      diag_ff <= page_ff == `PMIC_DIAG_PAGE;
    end
  end

  // Registered pin: one cycle after a flag sets, out of reset it is released
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pd_irq_oe_ff <= 1'b0;
      pd_irq_out_ff <= 1'b1;
    end else begin
      pd_irq_oe_ff <= ictl_ff[`PMIC_ICTL_OE];
      pd_irq_out_ff <= !(ictl_ff[`PMIC_ICTL_EN] && |pend_ff);
    end
  end

  // Direct control: bit i+3 enables force, bit i gives on/off
  for (genvar i = 0; i < 3; i++) begin : g_led
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        led_out_ff[i] <= 1'b0;
      end else begin
        led_out_ff[i] <= (led_ff[i + 3] ? led_ff[i] : LED_FUNC[i]) ^ led_pol_ff[i];
      end
    end
  end

  // MAC path: only CRS and COL depend on duplex
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      crs_ff <= 1'b0;
      col_ff <= 1'b0;
      rx_dv_ff <= 1'b0;
      rxd_ff <= 4'h0;
      mtx_en_ff <= 1'b0;
      mtxd_ff <= 4'h0;
    end else begin
      if (loop_en) begin
        rx_dv_ff <= MAC_TX_EN;
        rxd_ff <= MAC_TXD;
        mtx_en_ff <= 1'b0;
        mtxd_ff <= 4'h0;
      end else begin
        rx_dv_ff <= LINE_RX_DV;
        rxd_ff <= LINE_RXD;
        mtx_en_ff <= MAC_TX_EN && !pwr_ff;
        mtxd_ff <= MAC_TXD;
      end
      if (full_dup) begin
        crs_ff <= loop_en ? MAC_TX_EN : LINE_RX_DV;
        col_ff <= 1'b0;
      end else begin
        crs_ff <= MAC_TX_EN || LINE_RX_DV;
        col_ff <= LINE_COL && !loop_en;
      end
    end
  end

  // Energy-detect sequencer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ed_ff <= pmic_pkg::PMIC_ED_ACTIVE;
      ed_cnt_ff <= 32'h0000_0000;
      ed_pulse_ff <= 1'b0;
    end else begin
      case (ed_ff)
        pmic_pkg::PMIC_ED_ACTIVE: begin
          ed_pulse_ff <= 1'b0;
          ed_cnt_ff <= 32'h0000_0000;
          if (ed_en && !LINE.energy) ed_ff <= pmic_pkg::PMIC_ED_SLEEP;
        end
        pmic_pkg::PMIC_ED_SLEEP: begin
          if (!ed_en || LINE.energy) begin
            ed_ff <= pmic_pkg::PMIC_ED_ACTIVE;
          end else if (ed_cnt_ff == `PMIC_ED_PERIOD - 32'h0000_0001) begin
            ed_cnt_ff <= 32'h0000_0000;
            ed_pulse_ff <= 1'b1;
            ed_ff <= pmic_pkg::PMIC_ED_PULSE;
          end else begin
            ed_cnt_ff <= ed_cnt_ff + 32'h0000_0001;
          end
        end
        pmic_pkg::PMIC_ED_PULSE: begin
          // Activity cuts a pulse short so wake-up never waits on it
          if (!ed_en || LINE.energy) begin
            ed_cnt_ff <= 32'h0000_0000;
            ed_pulse_ff <= 1'b0;
            ed_ff <= pmic_pkg::PMIC_ED_ACTIVE;
          end else if (ed_cnt_ff == `PMIC_ED_PULSE_CYC - 1) begin
            ed_cnt_ff <= 32'h0000_0000;
            ed_pulse_ff <= 1'b0;
            ed_ff <= pmic_pkg::PMIC_ED_SLEEP;
          end else begin
            ed_cnt_ff <= ed_cnt_ff + 32'h0000_0001;
          end
        end
        default: ed_ff <= pmic_pkg::PMIC_ED_ACTIVE;
      endcase
    end
  end

  assign RDATA = rdata_ff;
  assign RVALID = rvalid_ff;
  assign PD_IRQ_OUT = pd_irq_out_ff;
  assign PD_IRQ_OE = pd_irq_oe_ff;
  assign LED_OUT = led_out_ff;
  assign MAC_CRS = crs_ff;
  assign MAC_COL = col_ff;
  assign MAC_RX_DV = rx_dv_ff;
  assign MAC_RXD = rxd_ff;
  assign MEDIA_TX_EN = mtx_en_ff;
  assign MEDIA_TXD = mtxd_ff;
  assign POWER_DOWN = pd_out_ff;
  assign FULL_DUPLEX = dup_ff;
  assign ED_TX_PULSE = ed_pulse_ff;
  assign DIAG_PAGE = diag_ff;
endmodule
